// ### shared/snwp_pkg.sv
package snwp_pkg;
   localparam int unsigned ADDR_W            = 13;
   localparam int unsigned BYTE_W            = 8;
   localparam int unsigned PAGE_BYTES        = 32;
   localparam int unsigned PAGE_IDX_W        = 5;
   localparam int unsigned DCNT_W            = PAGE_IDX_W + 1;
   localparam int unsigned HI_ADDR_BITS      = ADDR_W - BYTE_W;
   localparam int unsigned TIMER_W           = 16;
   localparam int unsigned CLK_FREQ_MHZ      = 25;
   localparam int unsigned BYTE_WRITE_TYP_US = 50;
   localparam int unsigned BYTE_WRITE_MAX_US = 100;
   localparam int unsigned BYTE_WRITE_CYCLES = BYTE_WRITE_TYP_US * CLK_FREQ_MHZ;
   localparam int unsigned BYTE_WRITE_MAX_CYCLES = BYTE_WRITE_MAX_US * CLK_FREQ_MHZ;
   // control byte field positions
   localparam int unsigned CTRL_CODE_MSB     = 7;
   localparam int unsigned CTRL_CODE_LSB     = 4;
   localparam int unsigned CTRL_SEL_MSB      = 3;
   localparam int unsigned CTRL_SEL_LSB      = 1;
   localparam int unsigned CTRL_DIR_BIT      = 0;
   localparam logic        DIR_WRITE         = 1'b0;
   // arbitrary device type code
   localparam logic [3:0]  DEV_TYPE_DEFAULT  = 4'h6;
   // bit counter landmarks within one nine-clock byte
   localparam logic [3:0]  BIT_LAST_DATA     = 4'h7;
   localparam logic [3:0]  BIT_ACK_SLOT      = 4'h8;
   localparam logic [3:0]  BIT_ACK_DONE      = 4'h9;
   localparam logic [3:0]  BIT_CNT_RESET     = 4'h0;
   localparam logic [12:0] PTR_RESET         = 13'h0000;

   typedef enum logic [2:0] {
      P_IDLE    = 3'b000,
      P_CTRL    = 3'b001,
      P_ADDR_HI = 3'b011,
      P_ADDR_LO = 3'b010,
      P_DATA    = 3'b110,
      P_SKIP    = 3'b100
   } snwp_phase_type;

   typedef enum logic [1:0] {
      E_IDLE  = 2'b00,
      E_ISSUE = 2'b01,
      E_WAIT  = 2'b11
   } snwp_eng_type;
endpackage : snwp_pkg

// ### rtl/snwp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module snwp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } snwp_sync_type;

   snwp_sync_type s;
   snwp_sync_type n;

   always_comb begin
      n      = s;
      n.meta = d;
      n.stab = s.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign q = s.stab;
endmodule : snwp_sync
`default_nettype wire

// ### rtl/snwp_page_buf.sv
`timescale 1ns/1ns
`default_nettype none
module snwp_page_buf #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned IDX_W = 5
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             we,
   input  wire logic [IDX_W-1:0] widx,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [IDX_W-1:0] ridx,
   output logic      [WIDTH-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } snwp_buf_type;

   snwp_buf_type s;
   snwp_buf_type n;

   always_comb begin
      n = s;
      if (we) begin
         n.mem[widx] = wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign rdata = s.mem[ridx];
endmodule : snwp_page_buf
`default_nettype wire

// ### rtl/snwp_top.sv
`timescale 1ns/1ns
`default_nettype none
module snwp_top
   import snwp_pkg::*;
#(
   parameter logic [3:0]  DEVICE_TYPE = DEV_TYPE_DEFAULT,
   parameter int unsigned BYTE_CYCLES = BYTE_WRITE_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              scl_clk,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   input  wire logic              wp,
   input  wire logic              select_strap_lsb,
   input  wire logic              select_strap_mid,
   input  wire logic              select_strap_msb,
   output logic                   mem_we,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic [BYTE_W-1:0]      mem_wdata,
   output logic                   busy,
   output logic                   wp_latched,
   output logic [ADDR_W-1:0]      addr_ptr
);
   // link side: bits sampled on the serial clock's rising edge
   typedef struct packed {
      logic [BYTE_W-1:0] shift;
   } snwp_link_type;

   typedef struct packed {
      logic                    scl_q;
      logic                    sda_q;
      snwp_phase_type          phase;
      logic [3:0]              bit_cnt;
      logic                    sda_oe;
      logic                    ack_pend;
      logic [HI_ADDR_BITS-1:0] addr_hi;
      logic [ADDR_W-1:0]       ptr;
      logic [ADDR_W-1:0]       start_addr;
      logic [PAGE_IDX_W-1:0]   wr_idx;
      logic [DCNT_W-1:0]       dcount;
      logic                    wp_lat;
      snwp_eng_type            eng;
      logic [DCNT_W-1:0]       eng_left;
      logic [PAGE_IDX_W-1:0]   eng_idx;
      logic [ADDR_W-1:0]       eng_addr;
      logic [TIMER_W-1:0]      timer;
      logic                    mem_we;
      logic [ADDR_W-1:0]       mem_addr;
      logic [BYTE_W-1:0]       mem_wdata;
   } snwp_core_type;

   snwp_link_type           lk;
   snwp_link_type           lk_n;
   snwp_core_type           s;
   snwp_core_type           n;

   logic [5:0]              pins_s;
   logic                    scl_s;
   logic                    sda_s;
   logic                    wp_s;
   logic [2:0]              strap_s;
   logic                    rise;
   logic                    fall;
   logic                    start_det;
   logic                    stop_det;
   logic                    eng_busy;
   logic                    ctrl_match;
   logic [BYTE_W-1:0]       rx_byte;
   logic                    buf_we;
   logic [PAGE_IDX_W-1:0]   buf_widx;
   logic [BYTE_W-1:0]       buf_wdata;
   logic [BYTE_W-1:0]       buf_rdata;

   // next address inside the same page
   function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
      logic [PAGE_IDX_W-1:0] off;
      off       = a[PAGE_IDX_W-1:0] + PAGE_IDX_W'(1);
      page_next = {a[ADDR_W-1:PAGE_IDX_W], off};
   endfunction : page_next

   // ------------------------------------------------------------------
   // link clock domain
   // ------------------------------------------------------------------
   always_comb begin
      lk_n       = lk;
      lk_n.shift = {lk.shift[BYTE_W-2:0], sda_in};
   end

   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk <= '0;
      end else begin
         lk <= lk_n;
      end
   end

   // ------------------------------------------------------------------
   // pin synchronisers into the core clock
   // ------------------------------------------------------------------
   snwp_sync #(
      .W (6)
   ) u_pin_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({select_strap_msb, select_strap_mid, select_strap_lsb,
               wp, sda_in, scl_clk}),
      .q     (pins_s)
   );

   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   assign wp_s    = pins_s[2];
   assign strap_s = pins_s[5:3];

   // ------------------------------------------------------------------
   // page buffer
   // ------------------------------------------------------------------
   snwp_page_buf #(
      .WIDTH (BYTE_W),
      .DEPTH (PAGE_BYTES),
      .IDX_W (PAGE_IDX_W)
   ) u_page_buf (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (buf_we),
      .widx  (buf_widx),
      .wdata (buf_wdata),
      .ridx  (s.eng_idx),
      .rdata (buf_rdata)
   );

   // ------------------------------------------------------------------
   // bus condition detection
   // ------------------------------------------------------------------
   // link shift register is stable for a whole serial bit after the rise,
   // so the synchronised rise qualifies it safely
   assign rx_byte   = lk.shift;
   assign rise      = scl_s & ~s.scl_q;
   assign fall      = ~scl_s & s.scl_q;
   // data edges only count while the clock was high on both samples
   assign start_det = scl_s & s.scl_q & s.sda_q & ~sda_s;
   assign stop_det  = scl_s & s.scl_q & ~s.sda_q & sda_s;
   assign eng_busy  = (s.eng != E_IDLE);

   assign ctrl_match =
      (rx_byte[CTRL_CODE_MSB:CTRL_CODE_LSB] == DEVICE_TYPE) &&
      (rx_byte[CTRL_SEL_MSB:CTRL_SEL_LSB] == strap_s) &&
      (rx_byte[CTRL_DIR_BIT] == DIR_WRITE);

   // ------------------------------------------------------------------
   // core next state
   // ------------------------------------------------------------------
   always_comb begin
      n         = s;
      buf_we    = 1'b0;
      buf_widx  = s.wr_idx;
      buf_wdata = rx_byte;
      n.scl_q   = scl_s;
      n.sda_q   = sda_s;
      n.mem_we  = 1'b0;

      // write engine: one array write per buffered byte
      case (s.eng)
         E_IDLE: begin
            n.timer = '0;
         end
         E_ISSUE: begin
            n.mem_we    = 1'b1;
            n.mem_addr  = s.eng_addr;
            n.mem_wdata = buf_rdata;
            n.timer     = TIMER_W'(BYTE_CYCLES - 2);
            n.eng       = E_WAIT;
         end
         E_WAIT: begin
            if (s.timer != '0) begin
               n.timer = s.timer - TIMER_W'(1);
            end else begin
               n.eng_idx  = s.eng_idx + PAGE_IDX_W'(1);
               n.eng_addr = page_next(s.eng_addr);
               n.eng_left = s.eng_left - DCNT_W'(1);
               if (s.eng_left == DCNT_W'(1)) begin
                  n.eng = E_IDLE;
               end else begin
                  n.eng = E_ISSUE;
               end
            end
         end
         default: begin
            n.eng = E_IDLE;
         end
      endcase

      // serial protocol
      if (start_det) begin
         n.phase    = P_CTRL;
         n.bit_cnt  = BIT_CNT_RESET;
         n.sda_oe   = 1'b0;
         n.ack_pend = 1'b0;
         n.dcount   = '0;
      end else if (stop_det) begin
         if ((s.phase == P_DATA) && (s.dcount != '0)) begin
            n.wp_lat = wp_s;
            if (!wp_s) begin
               n.eng      = E_ISSUE;
               n.eng_left = s.dcount;
               n.eng_idx  = '0;
               n.eng_addr = s.start_addr;
            end
         end
         n.phase    = P_IDLE;
         n.bit_cnt  = BIT_CNT_RESET;
         n.sda_oe   = 1'b0;
         n.ack_pend = 1'b0;
         n.dcount   = '0;
      end else if (rise && (s.phase != P_IDLE)) begin
         if (s.bit_cnt == BIT_LAST_DATA) begin
            n.bit_cnt  = BIT_ACK_SLOT;
            n.ack_pend = 1'b0;
            case (s.phase)
               P_CTRL: begin
                  n.dcount = '0;
                  if (ctrl_match && !eng_busy) begin
                     n.ack_pend = 1'b1;
                     n.phase    = P_ADDR_HI;
                  end else begin
                     n.phase = P_SKIP;
                  end
               end
               P_ADDR_HI: begin
                  n.addr_hi  = rx_byte[HI_ADDR_BITS-1:0];
                  n.ack_pend = 1'b1;
                  n.phase    = P_ADDR_LO;
               end
               P_ADDR_LO: begin
                  n.ptr        = {s.addr_hi, rx_byte};
                  n.start_addr = {s.addr_hi, rx_byte};
                  n.wr_idx     = '0;
                  n.dcount     = '0;
                  n.ack_pend   = 1'b1;
                  n.phase      = P_DATA;
               end
               P_DATA: begin
                  buf_we     = ce;
                  n.wr_idx   = s.wr_idx + PAGE_IDX_W'(1);
                  if (s.dcount != DCNT_W'(PAGE_BYTES)) begin
                     n.dcount = s.dcount + DCNT_W'(1);
                  end
                  n.ptr      = page_next(s.ptr);
                  n.ack_pend = 1'b1;
               end
               default: begin
                  n.ack_pend = 1'b0;
               end
            endcase
         end else if (s.bit_cnt == BIT_ACK_SLOT) begin
            n.bit_cnt = BIT_ACK_DONE;
         end else if (s.bit_cnt < BIT_LAST_DATA) begin
            n.bit_cnt = s.bit_cnt + 4'h1;
         end
      end else if (fall) begin
         if (s.bit_cnt == BIT_ACK_SLOT) begin
            n.sda_oe = s.ack_pend;
         end else if (s.bit_cnt == BIT_ACK_DONE) begin
            n.sda_oe   = 1'b0;
            n.ack_pend = 1'b0;
            n.bit_cnt  = BIT_CNT_RESET;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign sda_out    = 1'b0;
   assign sda_oe     = s.sda_oe;
   assign mem_we     = s.mem_we;
   assign mem_addr   = s.mem_addr;
   assign mem_wdata  = s.mem_wdata;
   assign busy       = eng_busy;
   assign wp_latched = s.wp_lat;
   assign addr_ptr   = s.ptr;
endmodule : snwp_top
`default_nettype wire

// ### test/snwp_chk.sv
`timescale 1ns/1ns
`default_nettype none
module snwp_chk
   import snwp_pkg::*;
#(
   parameter int unsigned BYTE_CYCLES = 8
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              sda_out,
   input wire logic              sda_oe,
   input wire logic              mem_we,
   input wire logic              busy,
   input wire logic              wp_latched,
   input wire logic [ADDR_W-1:0] addr_ptr,
   input wire logic [ADDR_W-1:0] mem_addr
);
   logic [15:0]       gap_q;
   logic [ADDR_W-1:0] nxt_a;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles since the last strobe while the cycle runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) gap_q <= 16'h0000;
      else if (mem_we) gap_q <= 16'h0001;
      else if (busy && gap_q != 16'h0000) gap_q <= gap_q + 16'h0001;
      else if (!busy) gap_q <= 16'h0000;
   end
   always_comb nxt_a = {mem_addr[12:5], mem_addr[4:0] + 5'h01};
   a_ack_pulls_low: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("ack drive not low");
   a_no_ack_busy: assert property (sda_oe |-> !busy)
      else $error("ack during write cycle");
   a_we_in_cycle: assert property (mem_we |-> busy)
      else $error("strobe outside cycle");
   a_first_strobe: assert property ($rose(busy) |=> mem_we)
      else $error("no strobe after cycle start");
   a_strobe_gap: assert property (mem_we && gap_q != 16'h0000 |-> gap_q == BYTE_CYCLES)
      else $error("strobe spacing wrong");
   a_busy_tail: assert property ($fell(busy) |-> gap_q == BYTE_CYCLES - 1)
      else $error("cycle length wrong");
   a_page_step: assert property (mem_we && gap_q != 16'h0000 |-> mem_addr == $past(nxt_a))
      else $error("strobe address not in-page successor");
   a_protect_off: assert property ($rose(busy) |-> !wp_latched)
      else $error("cycle started while protected");
   a_protect_held: assert property (busy && $past(busy) |-> $stable(wp_latched))
      else $error("protect changed in cycle");
   a_ptr_frozen: assert property (busy && $past(busy) |-> $stable(addr_ptr))
      else $error("pointer moved in cycle");
   c_cycle: cover property ($rose(busy));
   c_ack: cover property ($rose(sda_oe));
   c_page: cover property (mem_we && gap_q != 16'h0000);
endmodule : snwp_chk
bind snwp_top snwp_chk #(.BYTE_CYCLES(BYTE_CYCLES)) snwp_chk_inst (
   .clk(clk), .rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe), .mem_we(mem_we),
   .busy(busy), .wp_latched(wp_latched), .addr_ptr(addr_ptr), .mem_addr(mem_addr));
`default_nettype wire

// ### test/snwp_master.sv
`timescale 1ns/1ns
`default_nettype none
module snwp_master #(
   parameter int unsigned HALF = 516
) (
   output logic      scl,
   output logic      sda,
   input  wire logic sda_bus
);
   // bus idles high, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic start;
      sda = 1'b1;
      #HALF scl = 1'b1;
      #HALF sda = 1'b0;
      #HALF scl = 1'b0;
   endtask : start
   // ends a transfer after the last ack
   task automatic stop;
      sda = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda = 1'b1;
      #HALF;
   endtask : stop
   // msb first, then release and sample the ninth clock
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda = b[i];
         #HALF scl = 1'b1;
         #HALF scl = 1'b0;
      end
      sda = 1'b1;
      #HALF scl = 1'b1;
      #(HALF/2) ack = ~sda_bus;
      #(HALF/2) scl = 1'b0;
   endtask : send
endmodule : snwp_master
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import snwp_pkg::*;
   localparam int unsigned BC = 400;
   localparam logic [7:0]  CW = {DEV_TYPE_DEFAULT, 3'b101, DIR_WRITE};
   logic              clk, rst_n, wp, scl, sda_m, sda_oe, sda_out, mem_we, busy, wpl, ak;
   logic [ADDR_W-1:0] mem_addr, ptr;
   logic [BYTE_W-1:0] mem_wdata;
   logic [20:0]       log_q[$];
   int                error_cnt, n_compared, nk;
   logic [15:0]       ra [3] = '{16'h001F, 16'h07FF, 16'hE123};
   logic [7:0]        rd [3] = '{8'h5A, 8'hA5, 8'h3C};
   logic [12:0]       rp [3] = '{13'h0000, 13'h07E0, 13'h0124};
   logic [7:0]        bad [4] = '{CW ^ 8'h80, CW ^ 8'h02, CW ^ 8'h08, CW | 8'h01};
   wire logic         sda_w = sda_m & ~(sda_oe & ~sda_out);
   snwp_top #(.BYTE_CYCLES(BC)) snwp_top_inst (
      .clk(clk), .rst_n(rst_n), .ce(1'b1), .scl_clk(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .select_strap_lsb(1'b1),
      .select_strap_mid(1'b0), .select_strap_msb(1'b1), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy),
      .wp_latched(wpl), .addr_ptr(ptr));
   snwp_master snwp_master_inst (.scl(scl), .sda(sda_m), .sda_bus(sda_w));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (mem_we === 1'b1) log_q.push_back({mem_addr, mem_wdata});
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // control, address pair, n data bytes counting up from d0
   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0, input bit stp);
      logic [7:0] q[$];
      logic       ok;
      q = {CW, a[15:8], a[7:0]};
      ok = 1'b1;
      for (int k = 0; k < n; k++) q.push_back(d0 + 8'(k));
      log_q.delete();
      snwp_master_inst.start();
      foreach (q[i]) begin
         snwp_master_inst.send(q[i], ak);
         ok &= ak;
      end
      if (stp) snwp_master_inst.stop();
      check("ack", ok, 1);
   endtask : wr
   // same control byte until answered
   task automatic poll;
      nk = 0;
      do begin
         snwp_master_inst.start();
         snwp_master_inst.send(CW, ak);
         snwp_master_inst.stop();
         if (ak !== 1'b1) nk++;
      end while (ak !== 1'b1 && nk < 200);
   endtask : poll
   initial begin
      repeat (80000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   initial begin
      rst_n = 1'b0;
      wp = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      check("busy", busy, 0);
      check("ptr", ptr, 0);
      check("sda_oe", sda_oe, 0);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int r = 0; r < 3; r++) begin
         wr(ra[r], 1, rd[r], 1'b1);
         poll();
         check("refusals", nk > 0, 1);
         check("strobes", log_q.size(), 1);
         check("strobe", log_q[0], {ra[r][12:0], rd[r]});
         check("ptr", ptr, rp[r]);
         $display("row %0d done", r);
      end
      wr(16'h087A, 33, 8'h10, 1'b1);
      poll();
      check("strobes", log_q.size(), 32);
      for (int k = 0; k < 32; k++)
         check("page", log_q[k], {8'h43, 5'(5'h1A + k), k == 0 ? 8'h30 : 8'(8'h10 + k)});
      check("ptr", ptr, 13'h087B);
      $display("page test done");
      @(posedge clk) wp <= 1'b1;
      wr(16'h087A, 10, 8'h20, 1'b1);
      poll();
      check("refusals", nk, 0);
      check("strobes", log_q.size(), 0);
      check("ptr", ptr, 13'h0864);
      check("wpl", wpl, 1);
      $display("protect test done");
      @(posedge clk) wp <= 1'b0;
      wr(16'h0100, 1, 8'h77, 1'b1);
      @(posedge clk) wp <= 1'b1;
      poll();
      check("strobes", log_q.size(), 1);
      check("wpl", wpl, 0);
      $display("late protect test done");
      @(posedge clk) wp <= 1'b0;
      wr(16'h0200, 2, 8'h55, 1'b0);
      snwp_master_inst.start();
      snwp_master_inst.stop();
      check("busy", busy, 0);
      check("strobes", log_q.size(), 0);
      $display("abort test done");
      foreach (bad[i]) begin
         snwp_master_inst.start();
         snwp_master_inst.send(bad[i], ak);
         snwp_master_inst.stop();
         check("refuse", ak, 0);
      end
      $display("refusal test done");
      wr(16'h0300, 4, 8'h01, 1'b1);
      check("busy", busy, 1);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("busy", busy, 0);
      check("ptr", ptr, 0);
      check("sda_oe", sda_oe, 0);
      check("wpl", wpl, 0);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      $display("reset test done");
      summarize();
   end
endmodule : tb
`default_nettype wire
